// [core/uep_in_ep_dev.sv]
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module uep_in_ep_dev #(
    parameter logic [7:0] EP_INDEX   = 8'h01,
    parameter int         SLOT_BYTES = 64
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // register port
    input  wire logic [31:0] reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    // endpoint context
    input  wire logic [7:0]  ep_index_i,
    input  wire logic [3:0]  max_packet_size_i,
    input  wire logic        dma_mode_i,
    // fifo load
    input  wire logic        fifo_wr_i,
    input  wire logic [7:0]  fifo_data_i,
    output logic             fifo_ready_o,
    // events
    output logic             irq_o,
    // link
    uep_link_if.dev          link
);
    import uep_pkg::*;

    if (SLOT_BYTES != UEP_SLOT_BYTES) begin : g_bad_slot
        $error("uep_in_ep_dev: slot size must be 64");
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef enum logic [2:0] {
        UEP_D_IDLE = 3'b001,
        UEP_D_SEND = 3'b010,
        UEP_D_WACK = 3'b100
    } uep_dev_state_e;

    typedef struct packed {
        uep_dev_state_e  state;
        logic            tog_reset;
        logic            sent_stall;
        logic            stall_req;
        logic            flush;
        logic            auto_set;
        logic            iso;
        logic            dir_in;
        logic            int_mask;
        logic            toggle;
        logic            wr_slot;
        logic            rd_slot;
        logic [1:0]      queued;
        logic [1:0][6:0] cnt;
        logic [6:0]      rd_idx;
        logic [7:0]      rdata;
        logic            irq;
        logic            fifo_ready;
        logic            resp_valid;
        uep_resp_e       resp_code;
        logic            resp_pid1;
        logic [6:0]      resp_len;
        logic            dat_valid;
        logic            dat_last;
    } uep_dev_s;

    uep_dev_s    st_reg;
    uep_dev_s    st_next;
    logic [7:0]  mem [0:2*SLOT_BYTES-1];
    logic [7:0]  rd_q_reg;
    logic [6:0]  mp;
    logic        dual;
    logic [1:0]  nsl;
    logic        sel;
    logic        wr_ok;
    logic        commit;
    logic        freed;
    logic        drop;
    logic        ready_bit;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_next            = st_reg;
        st_next.resp_valid = 1'b0;
        st_next.dat_valid  = 1'b0;
        st_next.dat_last   = 1'b0;
        st_next.irq        = 1'b0;
        st_next.rdata      = 8'h00;
        mp        = uep_max_packet_size_bytes(max_packet_size_i);
        dual      = (max_packet_size_i == UEP_MAX_PACKET_SIZE_64);
        nsl       = dual ? 2'd2 : 2'd1;
        sel       = (ep_index_i == EP_INDEX);
        ready_bit = (st_reg.queued == nsl);
        wr_ok     = !ready_bit && (st_reg.cnt[st_reg.wr_slot] < mp);
        commit    = 1'b0;
        freed     = 1'b0;
        drop      = 1'b0;

        // register reads, reserved bits zero
        if (reg_rd_i && sel) begin
            if (reg_addr_i == UEP_CSR1_ADDR) begin
                st_next.rdata[UEP_C1_TOG]   = st_reg.tog_reset;
                st_next.rdata[UEP_C1_SENT]  = st_reg.sent_stall;
                st_next.rdata[UEP_C1_STALL] = st_reg.stall_req;
                st_next.rdata[UEP_C1_FLUSH] = st_reg.flush;
                st_next.rdata[UEP_C1_RDY]   = ready_bit;
            end else if (reg_addr_i == UEP_CSR2_ADDR) begin
                st_next.rdata[UEP_C2_AUTO] = st_reg.auto_set;
                st_next.rdata[UEP_C2_ISO]  = st_reg.iso;
                st_next.rdata[UEP_C2_DIR]  = st_reg.dir_in;
                st_next.rdata[UEP_C2_MASK] = st_reg.int_mask;
            end
        end

        // fifo load with auto-set on a full packet
        if (fifo_wr_i && wr_ok) begin
            st_next.cnt[st_reg.wr_slot] = st_reg.cnt[st_reg.wr_slot] + 7'd1;
            if (st_reg.auto_set && (st_reg.cnt[st_reg.wr_slot] + 7'd1 == mp)) begin
                commit = 1'b1;
            end
        end

        // register writes
        if (reg_wr_i && sel) begin
            if (reg_addr_i == UEP_CSR1_ADDR) begin
                st_next.tog_reset = reg_wdata_i[UEP_C1_TOG];
                if (!reg_wdata_i[UEP_C1_SENT]) begin
                    st_next.sent_stall = 1'b0;
                end
                st_next.stall_req = reg_wdata_i[UEP_C1_STALL];
                if (reg_wdata_i[UEP_C1_FLUSH]) begin
                    st_next.flush = 1'b1;
                end
                if (reg_wdata_i[UEP_C1_RDY] && !ready_bit) begin
                    commit = 1'b1;
                end
            end else if (reg_addr_i == UEP_CSR2_ADDR) begin
                st_next.auto_set = reg_wdata_i[UEP_C2_AUTO];
                st_next.iso      = reg_wdata_i[UEP_C2_ISO];
                st_next.dir_in   = reg_wdata_i[UEP_C2_DIR];
                st_next.int_mask = reg_wdata_i[UEP_C2_MASK];
            end
        end
        commit = commit && !st_next.stall_req;

        // link side; iso is held for software only, bulk is the one served mode
        case (st_reg.state)
            UEP_D_IDLE: begin
                if (link.tok) begin
                    st_next.resp_valid = 1'b1;
                    st_next.resp_len   = 7'h00;
                    st_next.resp_pid1  = 1'b0;
                    if (st_reg.stall_req) begin
                        st_next.resp_code  = UEP_RESP_STALL;
                        st_next.sent_stall = 1'b1;
                        drop = 1'b1;
                    end else if (!st_reg.dir_in || st_reg.queued == 2'd0) begin
                        st_next.resp_code = UEP_RESP_NAK;
                    end else begin
                        st_next.resp_code = UEP_RESP_DATA;
                        st_next.resp_pid1 = st_reg.toggle;
                        st_next.resp_len  = st_reg.cnt[st_reg.rd_slot];
                        st_next.rd_idx    = 7'h00;
                        if (st_reg.cnt[st_reg.rd_slot] == 7'h00) begin
                            st_next.state = UEP_D_WACK;
                        end else begin
                            st_next.state = UEP_D_SEND;
                        end
                    end
                end else if (st_reg.flush) begin
                    // flush only between transactions
                    st_next.flush = 1'b0;
                    st_next.irq   = 1'b1;
                    if (st_reg.queued != 2'd0) begin
                        freed = 1'b1;
                    end else begin
                        st_next.cnt[st_reg.wr_slot] = 7'h00;
                    end
                end
            end
            UEP_D_SEND: begin
                st_next.dat_valid = 1'b1;
                st_next.rd_idx    = st_reg.rd_idx + 7'd1;
                if (st_reg.rd_idx + 7'd1 == st_reg.cnt[st_reg.rd_slot]) begin
                    st_next.dat_last = 1'b1;
                    st_next.state    = UEP_D_WACK;
                end
            end
            UEP_D_WACK: begin
                if (link.ack) begin
                    freed          = 1'b1;
                    st_next.toggle = ~st_reg.toggle;
                    st_next.state  = UEP_D_IDLE;
                end
            end
            default: begin
                st_next.state = UEP_D_IDLE;
            end
        endcase
        if (st_next.tog_reset) begin
            st_next.toggle = 1'b0;
        end

        // packet queue bookkeeping
        if (freed) begin
            st_next.cnt[st_reg.rd_slot] = 7'h00;
            st_next.rd_slot = dual ? ~st_reg.rd_slot : 1'b0;
        end
        if (commit) begin
            st_next.wr_slot = dual ? ~st_reg.wr_slot : 1'b0;
        end
        st_next.queued = st_reg.queued + {1'b0, commit} - {1'b0, freed};
        if (drop) begin
            // stall empties every slot
            st_next.queued  = 2'd0;
            st_next.cnt     = '0;
            st_next.wr_slot = 1'b0;
            st_next.rd_slot = 1'b0;
        end
        if ((freed || (drop && st_reg.queued != 2'd0)) && !(dma_mode_i && st_reg.int_mask)) begin
            st_next.irq = 1'b1;
        end
        st_next.fifo_ready = (st_next.queued < nsl) && (st_next.cnt[st_next.wr_slot] < mp);
    end

    // ----------------------------------------
    // registers and buffer
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            st_reg            <= '0;
            st_reg.state      <= UEP_D_IDLE;
            st_reg.tog_reset  <= UEP_CSR1_RST[UEP_C1_TOG];
            st_reg.stall_req  <= UEP_CSR1_RST[UEP_C1_STALL];
            st_reg.auto_set   <= UEP_CSR2_RST[UEP_C2_AUTO];
            st_reg.iso        <= UEP_CSR2_RST[UEP_C2_ISO];
            st_reg.dir_in     <= UEP_CSR2_RST[UEP_C2_DIR];
            st_reg.int_mask   <= UEP_CSR2_RST[UEP_C2_MASK];
            st_reg.fifo_ready <= 1'b1;
            st_reg.resp_code  <= UEP_RESP_NAK;
            rd_q_reg          <= 8'h00;
        end else begin
            st_reg   <= st_next;
            rd_q_reg <= mem[{st_reg.rd_slot, st_reg.rd_idx[5:0]}];
        end
        if (fifo_wr_i && wr_ok) begin
            mem[{st_reg.wr_slot, st_reg.cnt[st_reg.wr_slot][5:0]}] <= fifo_data_i;
        end
    end

    assign reg_rdata_o     = st_reg.rdata;
    assign fifo_ready_o    = st_reg.fifo_ready;
    assign irq_o           = st_reg.irq;
    assign link.resp_valid = st_reg.resp_valid;
    assign link.resp_code  = st_reg.resp_code;
    assign link.resp_pid1  = st_reg.resp_pid1;
    assign link.resp_len   = st_reg.resp_len;
    assign link.dat_valid  = st_reg.dat_valid;
    assign link.dat_byte   = rd_q_reg;
    assign link.dat_last   = st_reg.dat_last;
endmodule // uep_in_ep_dev
`default_nettype wire

// [core/uep_pkg.sv]
package uep_pkg;
    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [31:0] UEP_CSR1_ADDR = 32'h5200_0184;
    localparam logic [31:0] UEP_CSR2_ADDR = 32'h5200_0188;
    localparam logic [7:0]  UEP_CSR1_RST  = 8'h00;
    localparam logic [7:0]  UEP_CSR2_RST  = 8'h20;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int UEP_C1_TOG   = 6;
    localparam int UEP_C1_SENT  = 5;
    localparam int UEP_C1_STALL = 4;
    localparam int UEP_C1_FLUSH = 3;
    localparam int UEP_C1_RDY   = 0;
    localparam int UEP_C2_AUTO  = 7;
    localparam int UEP_C2_ISO   = 6;
    localparam int UEP_C2_DIR   = 5;
    localparam int UEP_C2_MASK  = 4;
    // ----------------------------------------
    // max packet codes and link answers
    // ----------------------------------------
    localparam logic [3:0] UEP_MAX_PACKET_SIZE_8  = 4'h1;
    localparam logic [3:0] UEP_MAX_PACKET_SIZE_16 = 4'h2;
    localparam logic [3:0] UEP_MAX_PACKET_SIZE_32 = 4'h4;
    localparam logic [3:0] UEP_MAX_PACKET_SIZE_64 = 4'h8;
    localparam int         UEP_SLOT_BYTES = 64;

    typedef enum logic [1:0] {
        UEP_RESP_NAK   = 2'h0,
        UEP_RESP_STALL = 2'h1,
        UEP_RESP_DATA  = 2'h2
    } uep_resp_e;

    // reserved code 0000 falls back to the smallest size
    function automatic logic [6:0] uep_max_packet_size_bytes(input logic [3:0] code);
        case (code)
            UEP_MAX_PACKET_SIZE_16: uep_max_packet_size_bytes = 7'h10;
            UEP_MAX_PACKET_SIZE_32: uep_max_packet_size_bytes = 7'h20;
            UEP_MAX_PACKET_SIZE_64: uep_max_packet_size_bytes = 7'h40;
            default:     uep_max_packet_size_bytes = 7'h08;
        endcase
    endfunction
endpackage

// [core/uep_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface uep_link_if;
    logic              tok;
    logic              ack;
    logic              resp_valid;
    uep_pkg::uep_resp_e resp_code;
    logic              resp_pid1;
    logic [6:0]        resp_len;
    logic              dat_valid;
    logic [7:0]        dat_byte;
    logic              dat_last;

    modport dev (
        input  tok, ack,
        output resp_valid, resp_code, resp_pid1, resp_len, dat_valid, dat_byte, dat_last
    );
    modport hst (
        output tok, ack,
        input  resp_valid, resp_code, resp_pid1, resp_len, dat_valid, dat_byte, dat_last
    );
endinterface // uep_link_if
`default_nettype wire

// [core/uep_in_host.sv]
`timescale 1ns/1ps
`default_nettype none
module uep_in_host (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // commands
    input  wire logic        tok_req_i,
    output logic             busy_o,
    // results
    output logic             done_o,
    output uep_pkg::uep_resp_e result_o,
    output logic             pid1_o,
    output logic      [6:0]  len_o,
    output logic             rx_valid_o,
    output logic      [7:0]  rx_data_o,
    // link
    uep_link_if.hst          link
);
    import uep_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef enum logic [2:0] {
        UEP_H_IDLE  = 3'b001,
        UEP_H_WRESP = 3'b010,
        UEP_H_RECV  = 3'b100
    } uep_host_state_e;

    typedef struct packed {
        uep_host_state_e state;
        logic            tok;
        logic            ack;
        logic            busy;
        logic            done;
        uep_resp_e       result;
        logic            pid1;
        logic [6:0]      len;
        logic            rx_valid;
        logic [7:0]      rx_data;
    } uep_host_s;

    uep_host_s st_reg;
    uep_host_s st_next;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_next          = st_reg;
        st_next.tok      = 1'b0;
        st_next.ack      = 1'b0;
        st_next.done     = 1'b0;
        st_next.rx_valid = 1'b0;
        case (st_reg.state)
            UEP_H_IDLE: begin
                if (tok_req_i) begin
                    st_next.tok   = 1'b1;
                    st_next.busy  = 1'b1;
                    st_next.state = UEP_H_WRESP;
                end
            end
            UEP_H_WRESP: begin
                if (link.resp_valid) begin
                    st_next.result = link.resp_code;
                    st_next.pid1   = link.resp_pid1;
                    st_next.len    = link.resp_len;
                    if (link.resp_code == UEP_RESP_DATA && link.resp_len != 7'h00) begin
                        st_next.state = UEP_H_RECV;
                    end else begin
                        // handshake answers end here; a zero length packet is acked at once
                        st_next.ack   = (link.resp_code == UEP_RESP_DATA);
                        st_next.done  = 1'b1;
                        st_next.busy  = 1'b0;
                        st_next.state = UEP_H_IDLE;
                    end
                end
            end
            UEP_H_RECV: begin
                if (link.dat_valid) begin
                    st_next.rx_valid = 1'b1;
                    st_next.rx_data  = link.dat_byte;
                    if (link.dat_last) begin
                        // no error model: every whole packet is acknowledged
                        st_next.ack   = 1'b1;
                        st_next.done  = 1'b1;
                        st_next.busy  = 1'b0;
                        st_next.state = UEP_H_IDLE;
                    end
                end
            end
            default: begin
                st_next.state = UEP_H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            st_reg        <= '0;
            st_reg.state  <= UEP_H_IDLE;
            st_reg.result <= UEP_RESP_NAK;
        end else begin
            st_reg <= st_next;
        end
    end

    assign busy_o     = st_reg.busy;
    assign done_o     = st_reg.done;
    assign result_o   = st_reg.result;
    assign pid1_o     = st_reg.pid1;
    assign len_o      = st_reg.len;
    assign rx_valid_o = st_reg.rx_valid;
    assign rx_data_o  = st_reg.rx_data;
    assign link.tok   = st_reg.tok;
    assign link.ack   = st_reg.ack;
endmodule // uep_in_host
`default_nettype wire

// [tb/uep_link_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module uep_link_sva (
    // clock and reset
    input wire logic               clk_i,
    input wire logic               resetn_i,
    // link signals
    input wire logic               tok,
    input wire logic               ack,
    input wire logic               resp_valid,
    input wire uep_pkg::uep_resp_e resp_code,
    input wire logic [6:0]         resp_len,
    input wire logic               dat_valid,
    input wire logic               dat_last
);
    import uep_pkg::*;
    // ----------------------------------------
    // bytes seen against the announced length
    // ----------------------------------------
    logic [6:0] byte_cnt_reg;
    logic [6:0] len_reg;
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            byte_cnt_reg <= 7'h00;
            len_reg      <= 7'h00;
        end else if (resp_valid) begin
            byte_cnt_reg <= 7'h00;
            len_reg      <= resp_len;
        end else if (dat_valid) begin
            byte_cnt_reg <= byte_cnt_reg + 7'h01;
        end
    end
    // ----------------------------------------
    // link relations
    // ----------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    a_resp_after_tok: assert property (tok |=> resp_valid)
        else $error("token left unanswered");
    a_resp_needs_tok: assert property (resp_valid |-> $past(tok))
        else $error("answer without a token");
    a_stall_no_data: assert property (
        resp_valid && resp_code == UEP_RESP_STALL |=> !dat_valid && !ack)
        else $error("data after a stall answer");
    a_data_bytes_follow: assert property (
        resp_valid && resp_code == UEP_RESP_DATA && resp_len != 7'h00 |=> dat_valid)
        else $error("data answer without bytes");
    a_zero_len_ack: assert property (
        resp_valid && resp_code == UEP_RESP_DATA && resp_len == 7'h00 |=> ack)
        else $error("empty packet not acknowledged");
    a_burst_steady: assert property (dat_valid && !dat_last |=> dat_valid)
        else $error("gap inside a packet");
    a_last_has_byte: assert property (dat_last |-> dat_valid)
        else $error("last flag without a byte");
    a_last_then_ack: assert property (dat_last |=> ack)
        else $error("no acknowledge after last byte");
    a_byte_count: assert property (dat_last |-> byte_cnt_reg + 7'h01 == len_reg)
        else $error("byte count differs from length");
    a_len_bounded: assert property (resp_valid |-> resp_len <= 7'h40)
        else $error("length above largest packet");
endmodule // uep_link_sva
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import uep_pkg::*;
    typedef struct {string what; logic [15:0] v;} uep_tb_exp_s;
    logic clk_i, resetn_i, reg_wr_i, reg_rd_i, dma_mode_i, fifo_wr_i, tok_req_i;
    logic fifo_ready_o, irq_o, busy_o, done_o, pid1_o, rx_valid_o, rd_prev;
    logic [31:0] reg_addr_i;
    logic [7:0]  reg_wdata_i, reg_rdata_o, ep_index_i, fifo_data_i, rx_data_o;
    logic [3:0]  max_packet_size_i;
    logic [6:0]  len_o;
    uep_resp_e   result_o;
    logic [7:0]  fifo_q[$];
    uep_tb_exp_s exp_q[$];
    int n_errors, tests_run, n_irq, n_done;
    int seed = 32'h3BD1EE58;
    uep_link_if link();
    uep_in_ep_dev #(.EP_INDEX(8'h01), .SLOT_BYTES(64)) uep_in_ep_dev_inst (
        .clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .ep_index_i(ep_index_i),
        .max_packet_size_i(max_packet_size_i), .dma_mode_i(dma_mode_i),
        .fifo_wr_i(fifo_wr_i), .fifo_data_i(fifo_data_i), .fifo_ready_o(fifo_ready_o),
        .irq_o(irq_o), .link(link));
    uep_in_host uep_in_host_inst (
        .clk_i(clk_i), .resetn_i(resetn_i), .tok_req_i(tok_req_i), .busy_o(busy_o),
        .done_o(done_o), .result_o(result_o), .pid1_o(pid1_o), .len_o(len_o),
        .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o), .link(link));
    uep_link_sva uep_link_sva_inst (
        .clk_i(clk_i), .resetn_i(resetn_i), .tok(link.tok), .ack(link.ack),
        .resp_valid(link.resp_valid), .resp_code(link.resp_code), .resp_len(link.resp_len),
        .dat_valid(link.dat_valid), .dat_last(link.dat_last));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim;
        check("leftover notes", 16'(exp_q.size()), 16'h0000);
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic note(input string what, input logic [15:0] v);
        exp_q.push_back('{what, v});
    endtask
    // an empty queue yields a note that can never match
    function automatic uep_tb_exp_s take();
        uep_tb_exp_s e;
        e = '{"none", 16'hFFFF};
        if (exp_q.size() > 0) e = exp_q.pop_front();
        return e;
    endfunction
    // one idle cycle after each strobe so no signal is driven twice in a step
    task automatic acc(input logic wr, input logic [31:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_wr_i    <= wr;
        reg_rd_i    <= !wr;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        if (!wr) note("rdata", {8'h00, d});
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
    endtask
    task automatic load(input int n);
        logic [7:0] b;
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            b = 8'($random(seed));
            fifo_wr_i   <= 1'b1;
            fifo_data_i <= b;
            fifo_q.push_back(b);
        end
        @(posedge clk_i);
        fifo_wr_i <= 1'b0;
    endtask
    task automatic token(input uep_resp_e code, input logic pid, input int n);
        int d0;
        d0 = n_done;
        for (int i = 0; i < n; i++) note("rx", {8'h00, fifo_q.pop_front()});
        note("done", {6'h00, code, (code == UEP_RESP_DATA) ? {pid, 7'(n)} : 8'h00});
        @(posedge clk_i);
        tok_req_i <= 1'b1;
        @(posedge clk_i);
        tok_req_i <= 1'b0;
        @(negedge clk_i) check("busy", {15'h0000, busy_o}, 16'h0001);
        for (int i = 0; i < 200 && n_done == d0; i++) @(posedge clk_i);
        if (n_done == d0) n_errors++;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic drop(input int n);
        repeat (n) void'(fifo_q.pop_front());
    endtask
    // negative count means at least one pulse, the event split is open
    task automatic irq_is(input int e);
        check("irq", 16'((e < 0) ? (n_irq > 0) : n_irq), 16'((e < 0) ? 1 : e));
        n_irq = 0;
    endtask
    // ----------------------------------------
    // clock, observer, watchdog
    // ----------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(negedge clk_i) begin
        uep_tb_exp_s e;
        // last byte and done share a cycle, so each source takes its own note
        if (rd_prev === 1'b1) begin
            e = take();
            check(e.what, {8'h00, reg_rdata_o}, e.v);
        end
        if (rx_valid_o === 1'b1) begin
            e = take();
            check(e.what, {8'h00, rx_data_o}, e.v);
        end
        if (done_o === 1'b1) begin
            e = take();
            check(e.what, {6'h00, result_o,
                (result_o === UEP_RESP_DATA) ? {pid1_o, len_o} : 8'h00}, e.v);
        end
        rd_prev = reg_rd_i;
        if (irq_o === 1'b1) n_irq++;
        if (done_o === 1'b1) n_done++;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        end_sim();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {resetn_i, reg_wr_i, reg_rd_i, dma_mode_i, fifo_wr_i, tok_req_i} = '0;
        reg_addr_i = '0; reg_wdata_i = '0; fifo_data_i = '0;
        ep_index_i = 8'h01; max_packet_size_i = UEP_MAX_PACKET_SIZE_8;
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        acc(0, UEP_CSR1_ADDR, UEP_CSR1_RST);
        acc(0, UEP_CSR2_ADDR, UEP_CSR2_RST);
        acc(0, 32'h5200_018C, 8'h00);
        acc(1, UEP_CSR2_ADDR, 8'hFF);
        acc(0, UEP_CSR2_ADDR, 8'hF0);
        acc(1, UEP_CSR1_ADDR, 8'h80);
        acc(0, UEP_CSR1_ADDR, 8'h00);
        acc(1, UEP_CSR2_ADDR, 8'h20);
        ep_index_i <= 8'h02;
        acc(0, UEP_CSR2_ADDR, 8'h00);
        ep_index_i <= 8'h01;
        $display("test registers done");
        load(5);
        acc(1, UEP_CSR1_ADDR, 8'h01);
        acc(0, UEP_CSR1_ADDR, 8'h01);
        @(negedge clk_i);
        check("fifo_ready", {15'h0000, fifo_ready_o}, 16'h0000);
        acc(1, UEP_CSR2_ADDR, 8'h00);
        token(UEP_RESP_NAK, 0, 0);
        acc(1, UEP_CSR2_ADDR, 8'h20);
        token(UEP_RESP_DATA, 0, 5);
        irq_is(1);
        acc(0, UEP_CSR1_ADDR, 8'h00);
        acc(1, UEP_CSR1_ADDR, 8'h01);
        token(UEP_RESP_DATA, 1, 0);
        for (int k = 0; k < 3; k++) begin
            load(3);
            acc(1, UEP_CSR1_ADDR, (k < 2) ? 8'h41 : 8'h01);
            token(UEP_RESP_DATA, 0, 3);
        end
        acc(1, UEP_CSR2_ADDR, 8'hA0);
        load(8);
        acc(0, UEP_CSR1_ADDR, 8'h01);
        token(UEP_RESP_DATA, 1, 8);
        acc(1, UEP_CSR2_ADDR, 8'h20);
        irq_is(5);
        $display("test send and toggle done");
        load(3);
        acc(1, UEP_CSR1_ADDR, 8'h01);
        acc(1, UEP_CSR1_ADDR, 8'h11);
        token(UEP_RESP_STALL, 0, 0);
        drop(3);
        irq_is(1);
        acc(0, UEP_CSR1_ADDR, 8'h30);
        load(2);
        acc(1, UEP_CSR1_ADDR, 8'h31);
        acc(0, UEP_CSR1_ADDR, 8'h30);
        acc(1, UEP_CSR1_ADDR, 8'h00);
        acc(0, UEP_CSR1_ADDR, 8'h00);
        acc(1, UEP_CSR1_ADDR, 8'h01);
        token(UEP_RESP_DATA, 0, 2);
        irq_is(1);
        $display("test stall done");
        max_packet_size_i <= UEP_MAX_PACKET_SIZE_64;
        load(3);
        acc(1, UEP_CSR1_ADDR, 8'h01);
        load(4);
        acc(1, UEP_CSR1_ADDR, 8'h01);
        acc(0, UEP_CSR1_ADDR, 8'h01);
        acc(1, UEP_CSR1_ADDR, 8'h08);
        repeat (4) @(posedge clk_i);
        drop(3);
        irq_is(-1);
        acc(0, UEP_CSR1_ADDR, 8'h00);
        token(UEP_RESP_DATA, 1, 4);
        for (int k = 0; k < 2; k++) begin
            load(2);
            acc(1, UEP_CSR1_ADDR, 8'h01);
        end
        fork
            token(UEP_RESP_DATA, 0, 2);
            begin
                repeat (4) @(posedge clk_i);
                acc(1, UEP_CSR1_ADDR, 8'h08);
            end
        join
        drop(2);
        token(UEP_RESP_NAK, 0, 0);
        irq_is(-1);
        $display("test flush done");
        dma_mode_i <= 1'b1;
        acc(1, UEP_CSR2_ADDR, 8'h30);
        load(2);
        acc(1, UEP_CSR1_ADDR, 8'h01);
        token(UEP_RESP_DATA, 1, 2);
        irq_is(0);
        $display("test dma mask done");
        end_sim();
    end
endmodule // testbench
`default_nettype wire
